/* rtl/bus_decoder.sv */
// turns parallel pin activity into one-cycle read and write strobes
module bus_decoder
  import host_port_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_any,
  input  wire logic [1:0] bus_type_select,
  input  wire logic       chip_select_n,
  input  wire logic       strobe_e_rd_n,
  input  wire logic       rw_wr_n,
  input  wire logic       data_command_select,
  input  wire logic [7:0] host_data_in,
  strobe_if.decoder       sb
);
  typedef struct packed {
    logic e_q;
    logic rd_q;
    logic wr_q;
  } dec_s;
  dec_s state_reg;
  dec_s state_next;
  logic sel;
  logic e_rise;
  logic rd_fall;
  logic wr_fall;

  // edge detection of host strobes, gated by chip select
  always_comb begin
    sel               = !chip_select_n;
    state_next.e_q    = strobe_e_rd_n;
    state_next.rd_q   = strobe_e_rd_n;
    state_next.wr_q   = rw_wr_n;
    e_rise            = strobe_e_rd_n && !state_reg.e_q;
    rd_fall           = !strobe_e_rd_n && state_reg.rd_q;
    wr_fall           = !rw_wr_n && state_reg.wr_q;
  end

  always_ff @(posedge clk or posedge rst_any) begin
    if (rst_any) begin
      state_reg <= '{e_q: 1'b0, rd_q: 1'b1, wr_q: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // serial mode is not decoded here; only the parallel modes strobe
  always_comb begin
    sb.wr_pulse = 1'b0;
    sb.rd_pulse = 1'b0;
    if (sel && bus_type_select == BUS_6800) begin
      sb.wr_pulse = e_rise && !rw_wr_n;
      sb.rd_pulse = e_rise && rw_wr_n;
    end else if (sel && bus_type_select == BUS_8080) begin
      sb.rd_pulse = rd_fall;
      sb.wr_pulse = wr_fall;
    end
    sb.is_data = data_command_select;
    sb.wr_byte = host_data_in;
  end

  a_no_strobe_unsel : assert property (@(posedge clk) disable iff (rst_any)
    chip_select_n |-> !(sb.wr_pulse || sb.rd_pulse))
    else $error("strobe while chip deselected");
  a_6800_dir_write : assert property (@(posedge clk) disable iff (rst_any)
    sb.wr_pulse && bus_type_select == BUS_6800 |-> !rw_wr_n)
    else $error("6800 write with direction high");
  a_8080_read_edge : assert property (@(posedge clk) disable iff (rst_any)
    sb.rd_pulse && bus_type_select == BUS_8080 |-> $fell(strobe_e_rd_n))
    else $error("8080 read without falling strobe");
endmodule : bus_decoder

/* rtl/display_host_port.sv */
// device side of the display host port with reset and panel power logic
module display_host_port
  import host_port_pkg::*;
#(
  parameter int unsigned ON_DELAY_CYCLES = DISPLAY_ON_CYCLES,
  parameter int unsigned RST_CYCLES      = RESET_LOW_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   reset_n_input,
  input  wire logic [1:0]             bus_type_select,
  input  wire logic                   chip_select_n,
  input  wire logic                   strobe_e_rd_n,
  input  wire logic                   rw_wr_n,
  input  wire logic                   data_command_select,
  input  wire logic [7:0]             host_data_bus_in,
  output logic      [7:0]             host_data_bus_out,
  output logic                        host_data_bus_oe,
  output logic                        panel_drive_outputs,
  output logic                        config_default,
  output logic                        cmd_valid,
  output logic      [7:0]             cmd_byte,
  output logic                        data_valid,
  output logic      [7:0]             data_byte
);
  import host_port_pkg::*;

  // refuse counts that the timers cannot serve
  if (ON_DELAY_CYCLES < 1 || RST_CYCLES < 1) begin : g_bad_counts
    $error("delay counts must be at least one");
  end

  typedef struct packed {
    panel_e      panel;
    logic [31:0] on_cnt;
    logic [31:0] rst_cnt;
    logic        cfg_def;
    logic        cmd_v;
    logic [7:0]  cmd_b;
    logic        dat_v;
    logic [7:0]  dat_b;
    logic        oe;
    logic [7:0]  rd_b;
  } core_s;

  core_s    state_reg;
  core_s    state_next;
  logic     rst_any;
  strobe_if sb ();

  // decoder and core reset from sys_rst only; the reset pin low is handled in the next-state logic
  assign rst_any = sys_rst;

  bus_decoder u_dec (
    .clk                 (clk),
    .rst_any             (rst_any),
    .bus_type_select     (bus_type_select),
    .chip_select_n       (chip_select_n || !reset_n_input),
    .strobe_e_rd_n       (strobe_e_rd_n),
    .rw_wr_n             (rw_wr_n),
    .data_command_select (data_command_select),
    .host_data_in        (host_data_bus_in),
    .sb                  (sb)
  );

  // next state: reset pin handling, byte capture and display-on timer
  always_comb begin
    state_next       = state_reg;
    state_next.cmd_v = 1'b0;
    state_next.dat_v = 1'b0;
    if (!reset_n_input) begin
      state_next.panel = PANEL_OFF;
      state_next.oe    = 1'b0;
      state_next.on_cnt = '0;
      if (state_reg.rst_cnt >= 32'(RST_CYCLES - 1)) begin
        state_next.cfg_def = 1'b1;
      end else begin
        state_next.rst_cnt = state_reg.rst_cnt + 32'h1;
      end
    end else begin
      state_next.rst_cnt = '0;
      // data lines driven from the edge after a read strobe until the edge after it ends or chip select goes high
      if (sb.rd_pulse) begin
        state_next.oe = 1'b1;
      end else if (chip_select_n || (strobe_e_rd_n == (bus_type_select == BUS_8080))) begin
        state_next.oe = 1'b0;
      end
      if (sb.wr_pulse) begin
        state_next.cfg_def = 1'b0;
        if (sb.is_data) begin
          state_next.dat_v = 1'b1;
          state_next.dat_b = sb.wr_byte;
        end else begin
          state_next.cmd_v = 1'b1;
          state_next.cmd_b = sb.wr_byte;
        end
      end
      unique case (state_reg.panel)
        PANEL_OFF: begin
          if (sb.wr_pulse && !sb.is_data && sb.wr_byte == CMD_DISPLAY_ON) begin
            state_next.panel  = PANEL_WAIT;
            state_next.on_cnt = '0;
          end
        end
        PANEL_WAIT: begin
          if (sb.wr_pulse && !sb.is_data && sb.wr_byte == CMD_DISPLAY_OFF) begin
            state_next.panel = PANEL_OFF;
          end else if (state_reg.on_cnt >= 32'(ON_DELAY_CYCLES - 1)) begin
            state_next.panel = PANEL_ON;
          end else begin
            state_next.on_cnt = state_reg.on_cnt + 32'h1;
          end
        end
        PANEL_ON: begin
          // display-off drops the panel drive at once
          if (sb.wr_pulse && !sb.is_data && sb.wr_byte == CMD_DISPLAY_OFF) begin
            state_next.panel = PANEL_OFF;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg         <= '0;
      state_reg.panel   <= PANEL_OFF;
      state_reg.cfg_def <= 1'b1;
      state_reg.rd_b    <= READ_DATA_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs from flip-flops, the output enable also gated by bus_type_select; serial mode keeps the bus released
  assign host_data_bus_out   = state_reg.rd_b;
  assign host_data_bus_oe    = state_reg.oe && (bus_type_select != BUS_SERIAL);
  assign panel_drive_outputs = (state_reg.panel == PANEL_ON);
  assign config_default      = state_reg.cfg_def;
  assign cmd_valid           = state_reg.cmd_v;
  assign cmd_byte            = state_reg.cmd_b;
  assign data_valid          = state_reg.dat_v;
  assign data_byte           = state_reg.dat_b;

  sequence s_on_cmd;
    sb.wr_pulse && !sb.is_data && sb.wr_byte == CMD_DISPLAY_ON && reset_n_input
      && state_reg.panel == PANEL_OFF;
  endsequence

  a_panel_on_early : assert property (@(posedge clk) disable iff (sys_rst)
    s_on_cmd |=> !panel_drive_outputs throughout
      (state_reg.panel == PANEL_WAIT && state_reg.on_cnt == 32'h0))
    else $error("panel drive active too soon");
  a_panel_on_time : assert property (@(posedge clk) disable iff (sys_rst)
    $rose(panel_drive_outputs) |-> $past(state_reg.on_cnt) == 32'(ON_DELAY_CYCLES - 1))
    else $error("panel drive on before the delay ran out");
  a_cfg_after_rst : assert property (@(posedge clk) disable iff (sys_rst)
    (!reset_n_input && state_reg.rst_cnt >= 32'(RST_CYCLES - 1)) |=> config_default)
    else $error("configuration not at default after reset");
  a_reset_drops : assert property (@(posedge clk) disable iff (sys_rst)
    !reset_n_input |=> !panel_drive_outputs && !host_data_bus_oe)
    else $error("outputs active during reset");
  a_cmd_capture : assert property (@(posedge clk) disable iff (sys_rst)
    (sb.wr_pulse && !sb.is_data && reset_n_input) |=> cmd_valid && !data_valid
      && cmd_byte == $past(sb.wr_byte))
    else $error("command byte not captured");
  a_data_capture : assert property (@(posedge clk) disable iff (sys_rst)
    (sb.wr_pulse && sb.is_data && reset_n_input) |=> data_valid && !cmd_valid)
    else $error("data byte not captured");
endmodule : display_host_port

/* rtl/host_port_pkg.sv */
// constants and types shared by the display host port design
// How it works
// - config registers default after reset low interval
// - panel drive turns on 200 ms later
// - eight data lines form a bidirectional bus
// - 6800 mode: enable high with select starts transfer
// - 6800 mode: direction high reads, low writes
// - 8080 mode: read strobe low starts read
// - 8080 mode: write strobe low starts write
// - data/command high means data, low command
// - bus ignored unless chip select low
// - reset low initialises; host keeps it high
package host_port_pkg;
  localparam int          CLK_MHZ            = 250;
  localparam int          RESET_LOW_US       = 100;
  localparam int          RESET_LOW_CYCLES   = RESET_LOW_US * CLK_MHZ;
  localparam int          DISPLAY_ON_MS      = 200;
  localparam int          DISPLAY_ON_CYCLES  = DISPLAY_ON_MS * 1000 * CLK_MHZ;
  localparam logic [7:0]  CMD_DISPLAY_ON     = 8'hAF;
  localparam logic [7:0]  CMD_DISPLAY_OFF    = 8'hAE;
  localparam logic [1:0]  BUS_SERIAL         = 2'h0;
  localparam logic [1:0]  BUS_6800           = 2'h3;
  localparam logic [1:0]  BUS_8080           = 2'h2;
  localparam logic [7:0]  READ_DATA_RESET    = 8'h00;
  typedef enum logic [1:0] {
    PANEL_OFF,
    PANEL_WAIT,
    PANEL_ON
  } panel_e;
endpackage : host_port_pkg

/* rtl/strobe_if.sv */
// decoded transfer strobes between the pin decoder and the core
interface strobe_if;
  logic       wr_pulse;
  logic       rd_pulse;
  logic       is_data;
  logic [7:0] wr_byte;
  modport decoder (output wr_pulse, output rd_pulse, output is_data, output wr_byte);
  modport core    (input  wr_pulse, input  rd_pulse, input  is_data, input  wr_byte);
endinterface : strobe_if

/* test/host_model.sv */
// host microcontroller model that drives the display port pins
module host_model
  import host_port_pkg::*;
(
  input  wire logic       clk,
  output logic            reset_n_input,
  output logic      [1:0] bus_type_select,
  output logic            chip_select_n,
  output logic            strobe_e_rd_n,
  output logic            rw_wr_n,
  output logic            data_command_select,
  output logic      [7:0] host_drv,
  output logic            host_rel
);
  timeunit 1ns;
  timeprecision 1ps;
  // strobes rest inactive; the host drives an idle byte that never repeats the last byte
  task automatic idle();
    chip_select_n = 1'b1;
    host_rel      = 1'b0;
    host_drv      = ~host_drv & ((bus_type_select == BUS_SERIAL) ? 8'hFB : 8'hFF);
    strobe_e_rd_n = (bus_type_select == BUS_8080);
    rw_wr_n       = (bus_type_select == BUS_8080);
  endtask
  task automatic set_mode(input logic [1:0] m);
    bus_type_select = m;
    idle();
  endtask
  // one byte transfer; strobe stands for exactly one sampling edge
  task automatic xfer(input logic cs_n, input logic dc, input logic rd, input logic [7:0] b);
    @(negedge clk);
    chip_select_n       = cs_n;
    data_command_select = dc;
    host_drv            = b;
    host_rel            = rd;
    if (bus_type_select == BUS_8080) begin
      strobe_e_rd_n = !rd;
      rw_wr_n       = rd;
    end else if (bus_type_select == BUS_6800) begin
      rw_wr_n       = rd;
      strobe_e_rd_n = 1'b1;
    end
    @(negedge clk);
  endtask
  // device reset pulse; next transfer waits at least one more cycle
  task automatic pulse(input int n);
    @(negedge clk);
    reset_n_input = 1'b0;
    repeat (n) @(negedge clk);
    reset_n_input = 1'b1;
  endtask
  initial begin
    // supplies count as settled long before the first pulse
    reset_n_input = 1'b1;
    host_drv      = 8'h00;
    data_command_select = 1'b0;
    set_mode(BUS_8080);
  end
endmodule // host_model

/* test/tb_display_host_port.sv */
// self-checking bench for the display host port
module tb_display_host_port;
  timeunit 1ns;
  timeprecision 1ps;
  import host_port_pkg::*;
  localparam int unsigned ON_D  = 20;
  localparam int unsigned RST_D = 5;
  typedef struct packed {
    logic [1:0] mode; logic cs_n; logic dc; logic [7:0] b; logic ev_c; logic ev_d;
  } row_s;
  logic       clk, sys_rst, reset_n_input, chip_select_n, strobe_e_rd_n, rw_wr_n;
  logic       data_command_select, host_rel, oe, panel, cfg, cmd_valid, data_valid;
  logic [1:0] bus_type_select;
  logic [7:0] host_drv, bus_in, bus_out, cmd_byte, data_byte;
  int         error_cnt, n_compared;
  row_s       rows [7] = '{
    '{BUS_8080, 1'b0, 1'b0, 8'h3C, 1'b1, 1'b0}, '{BUS_8080, 1'b0, 1'b1, 8'h5A, 1'b0, 1'b1},
    '{BUS_6800, 1'b0, 1'b0, 8'hA5, 1'b1, 1'b0}, '{BUS_6800, 1'b0, 1'b1, 8'hC3, 1'b0, 1'b1},
    '{BUS_8080, 1'b1, 1'b1, 8'h77, 1'b0, 1'b0}, '{BUS_6800, 1'b1, 1'b0, 8'h11, 1'b0, 1'b0},
    '{BUS_SERIAL, 1'b0, 1'b1, 8'h99, 1'b0, 1'b0}};
  // wire level: device wins while it drives, else ~bus_out if the host has released, else host byte
  assign bus_in = oe ? bus_out : (host_rel ? ~bus_out : host_drv);
  host_model i_host (.clk(clk), .reset_n_input(reset_n_input), .bus_type_select(bus_type_select),
    .chip_select_n(chip_select_n), .strobe_e_rd_n(strobe_e_rd_n), .rw_wr_n(rw_wr_n),
    .data_command_select(data_command_select), .host_drv(host_drv), .host_rel(host_rel));
  display_host_port #(.ON_DELAY_CYCLES(ON_D), .RST_CYCLES(RST_D)) i_dut (.clk(clk),
    .sys_rst(sys_rst), .reset_n_input(reset_n_input), .bus_type_select(bus_type_select),
    .chip_select_n(chip_select_n), .strobe_e_rd_n(strobe_e_rd_n), .rw_wr_n(rw_wr_n),
    .data_command_select(data_command_select), .host_data_bus_in(bus_in),
    .host_data_bus_out(bus_out), .host_data_bus_oe(oe), .panel_drive_outputs(panel),
    .config_default(cfg), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .data_valid(data_valid), .data_byte(data_byte));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // write one byte, look at the pulse in its cycle and after it
  task automatic wr(input row_s r);
    i_host.set_mode(r.mode);
    i_host.xfer(r.cs_n, r.dc, 1'b0, r.b);
    check(cmd_valid === r.ev_c && data_valid === r.ev_d, "valid pulse");
    if (r.ev_c) check(cmd_byte === r.b, "command byte");
    if (r.ev_d) check(data_byte === r.b, "data byte");
    i_host.idle();
    @(negedge clk);
    check(cmd_valid === 1'b0 && data_valid === 1'b0, "pulse length");
  endtask
  task automatic rd(input logic [1:0] m);
    i_host.set_mode(m);
    i_host.xfer(1'b0, 1'b1, 1'b1, 8'h00);
    check(oe === 1'b1 && bus_out === READ_DATA_RESET, "read drive");
    i_host.idle();
    @(negedge clk);
    check(oe === 1'b0, "read release");
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // panel turn-on through the delay
  task automatic turn_on();
    wr('{BUS_8080, 1'b0, 1'b0, CMD_DISPLAY_ON, 1'b1, 1'b0});
    // accepted at the edge after the first falling edge of wr; on ON_D edges later
    repeat (ON_D - 2) @(negedge clk);
    check(panel === 1'b0, "panel early");
    @(negedge clk);
    check(panel === 1'b1, "panel late");
  endtask
  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
  initial begin
    error_cnt  = 0;
    n_compared = 0;
    sys_rst    = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    check(cfg === 1'b1 && panel === 1'b0 && oe === 1'b0, "reset state");
    $display("reset test done");
    for (int i = 0; i < 7; i++) wr(rows[i]);
    rd(BUS_8080);
    rd(BUS_6800);
    $display("transfer tests done");
    i_host.pulse(2);
    check(cfg === 1'b0, "defaults too early");
    i_host.pulse(RST_D + 2);
    check(cfg === 1'b1, "defaults after reset");
    turn_on();
    wr('{BUS_8080, 1'b0, 1'b0, CMD_DISPLAY_OFF, 1'b1, 1'b0});
    check(panel === 1'b0, "panel off");
    wr('{BUS_6800, 1'b0, 1'b0, CMD_DISPLAY_ON, 1'b1, 1'b0});
    wr('{BUS_6800, 1'b0, 1'b0, CMD_DISPLAY_OFF, 1'b1, 1'b0});
    repeat (ON_D + 5) @(negedge clk);
    check(panel === 1'b0, "aborted turn-on");
    turn_on();
    i_host.pulse(RST_D + 2);
    check(panel === 1'b0 && cfg === 1'b1, "reset drops panel");
    $display("panel tests done");
    complete_run();
  end
endmodule // tb_display_host_port
